// ### tb_top.sv
`timescale 1ns/10ps
module tb_top;
	logic core_clk_i, reset_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, irq_o, channel1_below_zero_i;
	logic [7:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, q;
	logic [3:0] pstrb_i;
	logic [1:0] pwm_mode_i, match_capture_a_i, match_capture_b_i, count_wrap_i, run, capture_c_o, capture_d_o;
	logic [1:0] timer_pin_c_i, timer_pin_d_i, timer_pin_c_o, timer_pin_d_o, timer_pin_c_oe_n_o, timer_pin_d_oe_n_o;
	logic [1:0][15:0] timer_counter_i, general_reg_c_i, general_reg_d_i, capture_c_value_o, capture_d_value_o;
	logic e, p, seen;
	int err_total, samples_checked, code;
	timer_cd_io_status timer_cd_io_status_inst (.*);
	tmr_far_model tmr_far_model_inst (.core_clk_i, .reset_i, .run_i(run), .count_o(timer_counter_i),
		.wrap_o(count_wrap_i));
	always #2 core_clk_i = ~core_clk_i;
	task automatic report_and_stop;
		if (err_total == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= {24'h0, d};
		@(posedge core_clk_i);
		penable_i <= 1'b1;
		do @(posedge core_clk_i); while (pready_o !== 1'b1 && ++n < 20);
		if (n >= 20) begin
			err_total++;
			report_and_stop();
		end
		q = prdata_o;
		e = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge core_clk_i);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
		apb(1'b0, a, 8'h00);
		chk(nm, exp, q);
	endtask
	initial begin
		{core_clk_i, psel_i, penable_i, pwrite_i, channel1_below_zero_i, paddr_i, pwdata_i} = '0;
		{pwm_mode_i, match_capture_a_i, match_capture_b_i, run, timer_pin_c_i, timer_pin_d_i} = '0;
		reset_i = 1'b1;
		pstrb_i = 4'hF;
		general_reg_c_i = {16'h0100, 16'h0005};
		general_reg_d_i = {16'h0100, 16'h0009};
		repeat (4) @(posedge core_clk_i);
		reset_i <= 1'b0;
		rd(8'h00, 32'h88, "ctrl_reset");
		rd(8'h04, 32'hE0, "stat0_reset");
		rd(8'h14, 32'hC0, "stat1_reset");
		rd(8'h08, 32'hE0, "enable_reset");
		apb(1'b0, 8'h0C, 8'h00);
		chk("unmapped_err", 32'h1, 32'(e));
		apb(1'b1, 8'h00, 8'hFF);
		rd(8'h00, 32'hFF, "ctrl_write");
		run <= 2'b01;
		for (int s = 0; s < 8; s += 4) begin
			for (code = 2; code > 0; code--) begin
				apb(1'b1, 8'h00, 8'(code << s));
				repeat (20) @(posedge core_clk_i);
				chk("pin_level", 32'(code - 1), 32'(s ? timer_pin_d_o[0] : timer_pin_c_o[0]));
				chk("pin_oe_n", 32'h0, 32'(s ? timer_pin_d_oe_n_o[0] : timer_pin_c_oe_n_o[0]));
			end
			apb(1'b1, 8'h00, 8'(3 << s));
			p = s ? timer_pin_d_o[0] : timer_pin_c_o[0];
			repeat (17) @(posedge core_clk_i);
			chk("pin_toggle", 32'(!p), 32'(s ? timer_pin_d_o[0] : timer_pin_c_o[0]));
		end
		pwm_mode_i <= 2'b01;
		repeat (3) @(posedge core_clk_i);
		chk("pwm_oe_n", 32'h3, 32'({timer_pin_c_oe_n_o[0], timer_pin_d_oe_n_o[0]}));
		pwm_mode_i <= 2'b00;
		run <= 2'b00;
		general_reg_c_i[0] <= 16'h0100;
		general_reg_d_i[0] <= 16'h0100;
		repeat (2) @(posedge core_clk_i);
		apb(1'b1, 8'h04, 8'h00);
		rd(8'h04, 32'hFC, "clear_unarmed");
		apb(1'b1, 8'h04, 8'h00);
		rd(8'h04, 32'hE0, "clear_armed");
		apb(1'b1, 8'h08, 8'h10);
		chk("irq_idle", 32'h0, 32'(irq_o));
		run <= 2'b01;
		repeat (20) @(posedge core_clk_i);
		chk("irq_wrap", 32'h1, 32'(irq_o));
		apb(1'b1, 8'h08, 8'h00);
		repeat (2) @(posedge core_clk_i);
		chk("irq_masked", 32'h0, 32'(irq_o));
		match_capture_a_i <= 2'b10;
		match_capture_b_i <= 2'b10;
		channel1_below_zero_i <= 1'b1;
		@(posedge core_clk_i);
		{match_capture_a_i, match_capture_b_i, channel1_below_zero_i} <= '0;
		rd(8'h14, 32'hE3, "stat1_flags");
		for (int s = 0; s < 8; s += 4) begin
			for (int k = 0; k < 6; k++) begin
				code = 4 + k / 2;
				if (k % 2 == 0) apb(1'b1, 8'h00, 8'(code << s));
				if (s == 0) timer_pin_c_i[0] <= (k % 2 == 0);
				else timer_pin_d_i[0] <= (k % 2 == 0);
				seen = 1'b0;
				repeat (8) begin
					@(posedge core_clk_i);
					seen |= (s ? capture_d_o[0] : capture_c_o[0]);
					if (s ? capture_d_o[0] : capture_c_o[0])
						chk("capture_value", 32'(4'(timer_counter_i[0][3:0] - 4'h1)),
							32'(s ? capture_d_value_o[0] : capture_c_value_o[0]));
				end
				chk("capture", 32'(code == 6 || (code == 4) == (k % 2 == 0)), 32'(seen));
			end
		end
		report_and_stop();
	end
endmodule

// ### timer_cd_defines.svh
`ifndef TIMER_CD_DEFINES_SVH
`define TIMER_CD_DEFINES_SVH

// Register byte offsets inside one channel window, and the channel window stride.
`define OFS_GR_CD_IO_CONTROL 4'h0
`define OFS_TIMER_STATUS_FLAGS 4'h4
`define OFS_TIMER_IRQ_ENABLE 4'h8
`define CH_SELECT_BIT 4

// Field positions.
`define IO_C_LSB 0
`define IO_D_LSB 4
`define FLAG_A_BIT 0
`define FLAG_B_BIT 1
`define FLAG_C_BIT 2
`define FLAG_D_BIT 3
`define FLAG_WRAP_BIT 4
`define FLAG_BELOW_ZERO_BIT 5
`define WRAP_IRQ_ENABLE_BIT 4

// Reserved bits that read as one, writable masks and reset values.
`define IO_RESERVED_ONES 8'h88
`define IO_WRITE_MASK 8'h77
`define IO_RESET 8'h00
`define STATUS_RESERVED_ONES_CH0 8'hE0
`define STATUS_RESERVED_ONES_CH1 8'hC0
`define FLAG_MASK_CH0 6'h1F
`define FLAG_MASK_CH1 6'h3F
`define FLAG_RESET 6'h00
`define IRQ_ENABLE_RESERVED_ONES 8'hE0
`define IRQ_ENABLE_WRITE_MASK 8'h1F
`define IRQ_ENABLE_RESET 8'h00

`endif

// ### timer_cd_io_status.sv
`timescale 1ns/10ps
`include "timer_cd_defines.svh"

module timer_cd_io_status import timer_cd_pkg::*; (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic pready_o,
	output logic [31:0] prdata_o,
	output logic pslverr_o,
	input wire logic [1:0] pwm_mode_i,
	input wire logic [1:0][15:0] timer_counter_i,
	input wire logic [1:0][15:0] general_reg_c_i,
	input wire logic [1:0][15:0] general_reg_d_i,
	input wire logic [1:0] match_capture_a_i,
	input wire logic [1:0] match_capture_b_i,
	input wire logic [1:0] count_wrap_i,
	input wire logic channel1_below_zero_i,
	input wire logic [1:0] timer_pin_c_i,
	input wire logic [1:0] timer_pin_d_i,
	output logic [1:0] timer_pin_c_o,
	output logic [1:0] timer_pin_c_oe_n_o,
	output logic [1:0] timer_pin_d_o,
	output logic [1:0] timer_pin_d_oe_n_o,
	output logic [1:0] capture_c_o,
	output logic [1:0][15:0] capture_c_value_o,
	output logic [1:0] capture_d_o,
	output logic [1:0][15:0] capture_d_value_o,
	output logic irq_o
);

	function automatic io_action_t decode_io(input io_select_t sel);
		io_action_t act;
		unique case (sel)
			3'h0: act = IO_NO_OUTPUT;
			3'h1: act = IO_DRIVE_LOW;
			3'h2: act = IO_DRIVE_HIGH;
			3'h3: act = IO_TOGGLE;
			3'h4: act = IO_CAPTURE_RISE;
			3'h5: act = IO_CAPTURE_FALL;
			3'h6: act = IO_CAPTURE_BOTH;
			3'h7: act = IO_CAPTURE_BOTH;
		endcase
		return act;
	endfunction

	// Capture edge qualification for one general register.
	function automatic logic capture_hit(input io_action_t act, input logic rise, input logic fall);
		return ((act == IO_CAPTURE_RISE) && rise) || ((act == IO_CAPTURE_FALL) && fall) ||
			((act == IO_CAPTURE_BOTH) && (rise || fall));
	endfunction

	// Pin level after a compare match for one general register.
	function automatic logic pin_on_match(input io_action_t act, input logic cur);
		logic nxt;
		nxt = cur;
		if (act == IO_DRIVE_LOW) begin
			nxt = 1'b0;
		end else if (act == IO_DRIVE_HIGH) begin
			nxt = 1'b1;
		end else if (act == IO_TOGGLE) begin
			nxt = ~cur;
		end
		return nxt;
	endfunction

	function automatic logic drives_pin(input io_action_t act);
		return (act == IO_DRIVE_LOW) || (act == IO_DRIVE_HIGH) || (act == IO_TOGGLE);
	endfunction

	// Bus side state.
	logic pready_r;
	logic [31:0] prdata_r;
	logic pslverr_r;
	logic [1:0][7:0] io_r;
	logic [1:0][7:0] irq_en_r;
	flag_vec_t [1:0] flag_r;
	flag_vec_t [1:0] armed_r;
	logic irq_r;

	// Pin side state.
	logic [1:0] pin_c_s1_r;
	logic [1:0] pin_c_s2_r;
	logic [1:0] pin_c_s3_r;
	logic [1:0] pin_d_s1_r;
	logic [1:0] pin_d_s2_r;
	logic [1:0] pin_d_s3_r;
	logic [1:0] pin_c_r;
	logic [1:0] pin_d_r;
	logic [1:0] pin_c_oe_n_r;
	logic [1:0] pin_d_oe_n_r;
	logic [1:0] cap_c_r;
	logic [1:0] cap_d_r;
	logic [1:0][15:0] cap_c_val_r;
	logic [1:0][15:0] cap_d_val_r;

	// APB decode. The slave answers with one wait state so read data comes from a flop.
	wire access = psel_i && penable_i;
	wire first_access = access && !pready_r;
	wire done = access && pready_r;
	wire [3:0] reg_ofs = {paddr_i[3:2], 2'b00};
	wire bus_ch = paddr_i[`CH_SELECT_BIT];
	wire addr_hit = (paddr_i[7:5] == 3'h0) && (paddr_i[1:0] == 2'h0) &&
		(reg_ofs != 4'hC);
	wire wr_ok = done && pwrite_i && addr_hit && pstrb_i[0];
	wire rd_ok = done && !pwrite_i && addr_hit;
	wire sel_io = reg_ofs == `OFS_GR_CD_IO_CONTROL;
	wire sel_status = reg_ofs == `OFS_TIMER_STATUS_FLAGS;
	wire sel_en = reg_ofs == `OFS_TIMER_IRQ_ENABLE;

	wire [7:0] status_ch0_rd = `STATUS_RESERVED_ONES_CH0 | {2'b00, flag_r[0]};
	wire [7:0] status_ch1_rd = `STATUS_RESERVED_ONES_CH1 | {2'b00, flag_r[1]};
	wire [7:0] status_rd = bus_ch ? status_ch1_rd : status_ch0_rd;
	wire [7:0] io_rd = io_r[bus_ch] | `IO_RESERVED_ONES;
	wire [7:0] en_rd = irq_en_r[bus_ch] | `IRQ_ENABLE_RESERVED_ONES;
	wire [7:0] byte_rd = sel_io ? io_rd : (sel_status ? status_rd : (sel_en ? en_rd : 8'h00));
	wire [31:0] rdata = addr_hit ? {24'h000000, byte_rd} : 32'h00000000;

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			pready_r <= 1'b0;
			prdata_r <= 32'h00000000;
			pslverr_r <= 1'b0;
		end else begin
			pready_r <= first_access;
			pslverr_r <= first_access && !addr_hit;
			if (first_access) begin
				prdata_r <= rdata;
			end
		end
	end

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_ch
			wire io_en = !pwm_mode_i[ch];
			wire io_c_cap = io_en && io_r[ch][`IO_C_LSB + 2];
			wire io_d_cap = io_en && io_r[ch][`IO_D_LSB + 2];
			wire io_action_t act_c = decode_io(io_r[ch][`IO_C_LSB +: 3]);
			wire io_action_t act_d = decode_io(io_r[ch][`IO_D_LSB +: 3]);
			wire rise_c = pin_c_s2_r[ch] && !pin_c_s3_r[ch];
			wire fall_c = !pin_c_s2_r[ch] && pin_c_s3_r[ch];
			wire rise_d = pin_d_s2_r[ch] && !pin_d_s3_r[ch];
			wire fall_d = !pin_d_s2_r[ch] && pin_d_s3_r[ch];
			wire cap_c = io_c_cap && capture_hit(act_c, rise_c, fall_c);
			wire cap_d = io_d_cap && capture_hit(act_d, rise_d, fall_d);
			wire cmp_c = !io_c_cap && (timer_counter_i[ch] == general_reg_c_i[ch]);
			wire cmp_d = !io_d_cap && (timer_counter_i[ch] == general_reg_d_i[ch]);
			wire drive_c = io_en && drives_pin(act_c);
			wire drive_d = io_en && drives_pin(act_d);
			wire below_zero = (ch == 1) ? channel1_below_zero_i : 1'b0;
			wire [5:0] flag_mask = (ch == 1) ? `FLAG_MASK_CH1 : `FLAG_MASK_CH0;
			wire flag_vec_t set_vec = {below_zero, count_wrap_i[ch], cap_d || cmp_d, cap_c || cmp_c,
				match_capture_b_i[ch], match_capture_a_i[ch]};
			wire ch_hit = bus_ch == 1'(ch);
			wire wr_status = wr_ok && ch_hit && sel_status;
			wire rd_status = rd_ok && ch_hit && sel_status;
			wire flag_vec_t clr_vec = wr_status ? (~pwdata_i[5:0] & armed_r[ch]) : 6'h00;
			wire flag_vec_t flag_nxt = (set_vec | (flag_r[ch] & ~clr_vec)) & flag_mask;
			wire flag_vec_t arm_vec = rd_status ? (prdata_r[5:0] & flag_r[ch]) : 6'h00;
			wire flag_vec_t armed_nxt = (armed_r[ch] | arm_vec) & ~clr_vec & flag_nxt;

			always_ff @(posedge core_clk_i) begin
				if (reset_i) begin
					io_r[ch] <= `IO_RESET;
					irq_en_r[ch] <= `IRQ_ENABLE_RESET;
					flag_r[ch] <= `FLAG_RESET;
					armed_r[ch] <= `FLAG_RESET;
				end else begin
					if (wr_ok && ch_hit && sel_io) begin
						io_r[ch] <= pwdata_i[7:0] & `IO_WRITE_MASK;
					end
					if (wr_ok && ch_hit && sel_en) begin
						irq_en_r[ch] <= pwdata_i[7:0] & `IRQ_ENABLE_WRITE_MASK;
					end
					flag_r[ch] <= flag_nxt;
					armed_r[ch] <= armed_nxt;
				end
			end

			always_ff @(posedge core_clk_i) begin
				if (reset_i) begin
					pin_c_s1_r[ch] <= 1'b0;
					pin_c_s2_r[ch] <= 1'b0;
					pin_c_s3_r[ch] <= 1'b0;
					pin_d_s1_r[ch] <= 1'b0;
					pin_d_s2_r[ch] <= 1'b0;
					pin_d_s3_r[ch] <= 1'b0;
				end else begin
					pin_c_s1_r[ch] <= timer_pin_c_i[ch];
					pin_c_s2_r[ch] <= pin_c_s1_r[ch];
					pin_c_s3_r[ch] <= pin_c_s2_r[ch];
					pin_d_s1_r[ch] <= timer_pin_d_i[ch];
					pin_d_s2_r[ch] <= pin_d_s1_r[ch];
					pin_d_s3_r[ch] <= pin_d_s2_r[ch];
				end
			end

			always_ff @(posedge core_clk_i) begin
				if (reset_i) begin
					pin_c_r[ch] <= 1'b0;
					pin_d_r[ch] <= 1'b0;
					pin_c_oe_n_r[ch] <= 1'b1;
					pin_d_oe_n_r[ch] <= 1'b1;
				end else begin
					pin_c_oe_n_r[ch] <= !drive_c;
					pin_d_oe_n_r[ch] <= !drive_d;
					if (drive_c && cmp_c) begin
						pin_c_r[ch] <= pin_on_match(act_c, pin_c_r[ch]);
					end
					if (drive_d && cmp_d) begin
						pin_d_r[ch] <= pin_on_match(act_d, pin_d_r[ch]);
					end
				end
			end

			always_ff @(posedge core_clk_i) begin
				if (reset_i) begin
					cap_c_r[ch] <= 1'b0;
					cap_d_r[ch] <= 1'b0;
					cap_c_val_r[ch] <= 16'h0000;
					cap_d_val_r[ch] <= 16'h0000;
				end else begin
					cap_c_r[ch] <= cap_c;
					cap_d_r[ch] <= cap_d;
					if (cap_c) begin
						cap_c_val_r[ch] <= timer_counter_i[ch];
					end
					if (cap_d) begin
						cap_d_val_r[ch] <= timer_counter_i[ch];
					end
				end
			end
		end
	endgenerate

	// Bit 4 of the channel 1 enable gates both the wrap and the below-zero flag; channel 0 masks below-zero off.
	wire [5:0] irq_mask0 = {1'b0, irq_en_r[0][4:0]};
	wire [5:0] irq_mask1 = {irq_en_r[1][`WRAP_IRQ_ENABLE_BIT], irq_en_r[1][4:0]};
	wire irq_nxt = |(flag_r[0] & irq_mask0) || |(flag_r[1] & irq_mask1);

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= irq_nxt;
		end
	end

	assign pready_o = pready_r;
	assign prdata_o = prdata_r;
	assign pslverr_o = pslverr_r;
	assign timer_pin_c_o = pin_c_r;
	assign timer_pin_c_oe_n_o = pin_c_oe_n_r;
	assign timer_pin_d_o = pin_d_r;
	assign timer_pin_d_oe_n_o = pin_d_oe_n_r;
	assign capture_c_o = cap_c_r;
	assign capture_c_value_o = cap_c_val_r;
	assign capture_d_o = cap_d_r;
	assign capture_d_value_o = cap_d_val_r;
	assign irq_o = irq_r;

endmodule

// ### timer_cd_io_status_checker.sv
`timescale 1ns/10ps
module timer_cd_io_status_checker (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic pready_o,
	input wire logic [31:0] prdata_o,
	input wire logic pslverr_o,
	input wire logic [1:0] pwm_mode_i,
	input wire logic [1:0] timer_pin_c_oe_n_o,
	input wire logic [1:0] timer_pin_d_oe_n_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (reset_i);
	wire rd_ok = pready_o && !pwrite_i && !pslverr_o;
	a_wait_state: assert property (psel_i && penable_i && !pready_o |=> pready_o) else $error("no answer");
	a_ready_pulse: assert property (pready_o |=> !pready_o) else $error("ready too long");
	a_bad_addr: assert property (pready_o && (paddr_i[1:0] != 2'h0 || paddr_i[3:2] == 2'h3) |->
		pslverr_o && prdata_o == 32'h0)
		else $error("unmapped not refused");
	a_upper_zero: assert property (pready_o |-> prdata_o[31:8] == 24'h0) else $error("upper data set");
	a_ctrl_ones: assert property (rd_ok && paddr_i[3:0] == 4'h0 |-> prdata_o[7] && prdata_o[3])
		else $error("control reserved bits");
	a_stat0_ones: assert property (rd_ok && paddr_i == 8'h04 |-> prdata_o[7:5] == 3'h7)
		else $error("status0 reserved bits");
	a_stat1_ones: assert property (rd_ok && paddr_i == 8'h14 |-> prdata_o[7:6] == 2'h3)
		else $error("status1 reserved bits");
	a_pwm_release: assert property (pwm_mode_i[0] && $past(pwm_mode_i[0]) |->
		timer_pin_c_oe_n_o[0] && timer_pin_d_oe_n_o[0]) else $error("pin driven in pwm");
endmodule
bind timer_cd_io_status timer_cd_io_status_checker timer_cd_io_status_checker_inst (.core_clk_i, .reset_i,
	.psel_i, .penable_i, .pwrite_i, .paddr_i, .pready_o, .prdata_o, .pslverr_o, .pwm_mode_i,
	.timer_pin_c_oe_n_o, .timer_pin_d_oe_n_o);

// ### timer_cd_pkg.sv
package timer_cd_pkg;

	typedef logic [2:0] io_select_t;

	typedef enum logic [2:0] {
		IO_NO_OUTPUT,
		IO_DRIVE_LOW,
		IO_DRIVE_HIGH,
		IO_TOGGLE,
		IO_CAPTURE_RISE,
		IO_CAPTURE_FALL,
		IO_CAPTURE_BOTH
	} io_action_t;

	typedef logic [5:0] flag_vec_t;

endpackage

// ### tmr_far_model.sv
`timescale 1ns/10ps
module tmr_far_model (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic [1:0] run_i,
	output logic [1:0][15:0] count_o,
	output logic [1:0] wrap_o
);
	// The counter wraps every 16 counts so that compare matches come often.
	always_ff @(posedge core_clk_i) begin
		for (int i = 0; i < 2; i++) begin
			wrap_o[i] <= 1'b0;
			if (reset_i) begin
				count_o[i] <= 16'h0000;
			end else if (run_i[i]) begin
				count_o[i] <= {12'h000, count_o[i][3:0] + 4'h1};
				wrap_o[i] <= (count_o[i][3:0] == 4'hF);
			end
		end
	end
endmodule
